/* File: ddc_assertions.sv */
`timescale 1ns/1ps
module ddc_assertions
    import ddc_pkg::*;
(
    input wire logic        CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0]  HTRANS_IN,
    input wire logic        HWRITE_IN,
    input wire logic        HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic        HREADYOUT_OUT,
    input wire logic        HRESP_OUT,
    input wire sample_t     OUT_SAMPLE_OUT,
    input wire logic        OUT_VALID_OUT,
    input wire logic        OUT_READY_IN
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    wire take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    wire rd   = take && !HWRITE_IN;
    wire bad  = HADDR_IN[31:8] != 24'h000000;
    sequence one_wait;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    sequence held;
        OUT_VALID_OUT && $stable(OUT_SAMPLE_OUT);
    endsequence
    bus_okay_a: assert property (HRESP_OUT == 1'b0)
        else $error("response not okay");
    write_nowait_a: assert property (take && HWRITE_IN |=> HREADYOUT_OUT)
        else $error("write stalled");
    read_wait_a: assert property (rd |=> one_wait)
        else $error("read wait not one cycle");
    unmapped_read_a: assert property (
        rd && bad |=> one_wait ##0 HRDATA_OUT == 32'h00000000)
        else $error("unmapped read not zero");
    wait_cause_a: assert property (!HREADYOUT_OUT |-> $past(rd))
        else $error("wait without read");
    rdata_idle_a: assert property (
        HREADYOUT_OUT && $past(HREADYOUT_OUT) |-> HRDATA_OUT == 32'h0)
        else $error("read data outside data phase");
    out_hold_a: assert property (OUT_VALID_OUT && !OUT_READY_IN |=> held)
        else $error("output dropped while stalled");
    reset_quiet_a: assert property (
        $rose(RSTN_IN) |-> !OUT_VALID_OUT && HREADYOUT_OUT)
        else $error("outputs active after reset");
endmodule // ddc_assertions
bind decimating_down_converter ddc_assertions u_ddc_assertions (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .OUT_SAMPLE_OUT(OUT_SAMPLE_OUT), .OUT_VALID_OUT(OUT_VALID_OUT),
    .OUT_READY_IN(OUT_READY_IN));

/* File: ddc_pkg.sv */
package ddc_pkg;
    localparam int ADC_W      = 18;
    localparam int DW         = 20;
    localparam int ACC_W      = 25;
    localparam int CNT_W      = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int FCNT_W     = $clog2(FIFO_DEPTH) + 1;
    localparam int SAMPLE_W   = 2 * DW + 1;
    localparam int PROD_LSB   = 15;
    localparam int PROD_MSB   = PROD_LSB + DW - 1;
    localparam int LUT_W      = 4;
    localparam int PHASE_W    = 32;
    localparam int ADDR_W     = 8;
    localparam int HT_BIT     = 1;

    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_FREQ = 8'h04;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] A_ACT  = 8'h0c;

    localparam int CTRL_W = 12;
    localparam int C_EN   = 0;
    localparam int C_REAL = 1;
    localparam int C_FS4  = 2;
    localparam int C_G6   = 3;
    localparam int C_G3   = 4;
    localparam int C_NEG  = 5;
    localparam int C_INV  = 6;
    localparam int C_RST  = 7;
    localparam int C_ALN  = 8;
    localparam int C_DEC  = 9;
    localparam int C_DECW = 3;

    localparam int S_OVR  = 0;
    localparam int S_PEND = 1;
    localparam int S_CNT  = 4;
    localparam int S_ALN  = 9;

    localparam logic [CTRL_W-1:0]  CTRL_RST = 12'h000;
    localparam logic [PHASE_W-1:0] FREQ_RST = 32'h0000_0000;
    localparam logic [C_DECW-1:0]  DEC_MAX  = 3'h4;
    localparam logic [LUT_W-1:0]   LUT_QTR  = 4'h4;

    typedef logic signed [DW-1:0]    word_t;
    typedef logic signed [ACC_W-1:0] acc_t;

    localparam word_t WORD_ZERO = 20'sh00000;
    localparam acc_t  ACC_WMAX  = 25'sh007ffff;
    localparam acc_t  ACC_WMIN  = -25'sh0080000;

    typedef struct packed {
        logic  is_real;
        word_t i;
        word_t q;
    } sample_t;

    typedef enum logic [1:0] {
        ST_EMPTY = 2'b00,
        ST_ONE   = 2'b01,
        ST_TWO   = 2'b10
    } stage_t;
endpackage

/* File: decimating_down_converter.sv */
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// What this block does
// - complex decimation by 2, 4, 8, 16, 32
// - complex path: shift, low-pass, then decimate
// - optional 6 dB gain in complex mode
// - real mode: no shift, real filter only
// - optional 3 dB gain in real mode
// - real passband half of complex passband
// - quarter-rate mix gives real samples, double rate
// - 32-bit oscillator, positive or negative rotation
// - real sample times complex oscillator sequence
// - frequency word is signed two's complement
// - new frequency waits for restart or align toggle
// - optional mixer phase inversion
// - filters reject stopband, pass most of band
// - filter accumulates at 25 bits, output saturated to 20 bits
// - real mode bypasses the mixer
// - align event resets phase, loads frequency
module decimating_down_converter
    import ddc_pkg::*;
(
    input  wire logic                    CLK_IN,
    input  wire logic                    RSTN_IN,
    input  wire logic                    HSEL_IN,
    input  wire logic [31:0]             HADDR_IN,
    input  wire logic [1:0]              HTRANS_IN,
    input  wire logic                    HWRITE_IN,
    input  wire logic [2:0]              HSIZE_IN,
    input  wire logic [31:0]             HWDATA_IN,
    input  wire logic                    HREADY_IN,
    output logic      [31:0]             HRDATA_OUT,
    output logic                         HREADYOUT_OUT,
    output logic                         HRESP_OUT,
    input  wire logic signed [ADC_W-1:0] ADC_DATA_IN,
    input  wire logic                    ADC_VALID_IN,
    input  wire logic                    POWERDOWN_OR_ALIGN_PIN_IN,
    output sample_t                      OUT_SAMPLE_OUT,
    output logic                         OUT_VALID_OUT,
    input  wire logic                    OUT_READY_IN
);
    function automatic logic [2:0] dec_shift(input logic [C_DECW-1:0] sel);
        return ((sel > DEC_MAX) ? DEC_MAX : sel) + 3'h1;
    endfunction

    function automatic logic signed [ADC_W-1:0] lut_cos(
        input logic [LUT_W-1:0] k);
        case (k)
            4'h0:    lut_cos = 18'sh1ffff;
            4'h1:    lut_cos = 18'sh1d907;
            4'h2:    lut_cos = 18'sh16a09;
            4'h3:    lut_cos = 18'sh0c3ef;
            4'h4:    lut_cos = 18'sh00000;
            4'h5:    lut_cos = -18'sh0c3ef;
            4'h6:    lut_cos = -18'sh16a09;
            4'h7:    lut_cos = -18'sh1d907;
            4'h8:    lut_cos = -18'sh1ffff;
            4'h9:    lut_cos = -18'sh1d907;
            4'ha:    lut_cos = -18'sh16a09;
            4'hb:    lut_cos = -18'sh0c3ef;
            4'hc:    lut_cos = 18'sh00000;
            4'hd:    lut_cos = 18'sh0c3ef;
            4'he:    lut_cos = 18'sh16a09;
            default: lut_cos = 18'sh1d907;
        endcase
    endfunction

    function automatic word_t sat_w(input acc_t v);
        if (v > ACC_WMAX) begin
            return ACC_WMAX[DW-1:0];
        end else if (v < ACC_WMIN) begin
            return ACC_WMIN[DW-1:0];
        end
        return v[DW-1:0];
    endfunction

    function automatic word_t gain_sat(input acc_t v, input logic g6,
                                       input logic g3);
        acc_t w;
        w = v;
        if (g6) begin
            w = v <<< 1;
        end else if (g3) begin
            w = v + (v >>> 2) + (v >>> 3) + (v >>> 5);
        end
        return sat_w(w);
    endfunction

    function automatic word_t neg_sat(input word_t v);
        return sat_w(-acc_t'(v));
    endfunction

    // bus slave
    logic                ap_take;
    logic                wr_q;
    logic                rd_q;
    logic                hit_q;
    logic [ADDR_W-1:0]   addr_q;
    logic [31:0]         hrdata_q;
    logic                hready_q;
    logic                hresp_q;
    logic [31:0]         rd_mux;
    logic                wr_ctrl;
    logic                wr_freq;
    logic                wr_stat;

    // settings
    logic [CTRL_W-1:0]   ctrl_q;
    logic [PHASE_W-1:0]  freq_pend_q;
    logic [PHASE_W-1:0]  freq_act_q;
    logic                pend_q;
    logic                ovr_q;
    logic                rst_prev_q;
    logic                al1_q;
    logic                al2_q;
    logic                al3_q;
    logic                en;
    logic                real_m;
    logic                fs4_eff;
    logic                g6_eff;
    logic                g3_eff;
    logic                q_neg;
    logic [2:0]          sh;
    logic [CNT_W-1:0]    last_cnt;
    logic                align_ev;
    logic                restart;
    logic [31:0]         status_w;

    // datapath
    logic [PHASE_W-1:0]          phase_q;
    logic [LUT_W-1:0]            idx;
    logic signed [ADC_W-1:0]     cos_v;
    logic signed [ADC_W-1:0]     sin_v;
    logic signed [2*ADC_W-1:0]   prod_i;
    logic signed [2*ADC_W-1:0]   prod_q;
    word_t                       mix_i;
    word_t                       mix_q;
    word_t                       q_raw;
    acc_t                        acc_i_q;
    acc_t                        acc_q_q;
    acc_t                        sum_i;
    acc_t                        sum_q;
    logic [CNT_W-1:0]            cnt_q;
    logic                        is_last;
    logic                        accept;
    logic                        load;
    logic                        ovr_set;

    // output stage and fifo
    stage_t                      st_q;
    stage_t                      st_d;
    word_t                       st_i_q;
    word_t                       st_qd_q;
    logic                        st_fs4_q;
    logic                        st_real_q;
    logic                        st_rot_q;
    logic                        rot_q;
    logic                        push;
    logic                        stage_free;
    word_t                       fs4_w;
    sample_t                     fifo_in;
    logic                        fifo_in_ready;
    sample_t                     fifo_out;
    logic                        fifo_out_valid;
    logic                        fifo_out_ready;
    logic [FCNT_W-1:0]           fifo_cnt;
    sample_t                     out_q;
    logic                        out_v_q;

    assign ap_take = HSEL_IN & HREADY_IN & HTRANS_IN[HT_BIT];
    assign wr_ctrl = wr_q & hit_q & (addr_q == A_CTRL);
    assign wr_freq = wr_q & hit_q & (addr_q == A_FREQ);
    assign wr_stat = wr_q & hit_q & (addr_q == A_STAT);
    assign rd_mux  = !hit_q ? 32'h0000_0000 :
                     (addr_q == A_CTRL) ? 32'(ctrl_q) :
                     (addr_q == A_FREQ) ? freq_pend_q :
                     (addr_q == A_STAT) ? status_w :
                     (addr_q == A_ACT)  ? freq_act_q : 32'h0000_0000;

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            hit_q    <= 1'b0;
            addr_q   <= '0;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
        end else begin
            wr_q     <= ap_take & HWRITE_IN;
            rd_q     <= ap_take & ~HWRITE_IN;
            hready_q <= ~(ap_take & ~HWRITE_IN);
            hresp_q  <= 1'b0;
            if (ap_take) begin
                addr_q <= HADDR_IN[ADDR_W-1:0];
                hit_q  <= HADDR_IN[31:ADDR_W] == '0;
            end
            hrdata_q <= rd_q ? rd_mux : 32'h0000_0000;
        end
    end

    assign HRDATA_OUT    = hrdata_q;
    assign HREADYOUT_OUT = hready_q;
    assign HRESP_OUT     = hresp_q;

    assign en       = ctrl_q[C_EN];
    assign real_m   = ctrl_q[C_REAL];
    assign fs4_eff  = ctrl_q[C_FS4] & ~real_m;
    assign g6_eff   = ctrl_q[C_G6] & ~real_m;
    assign g3_eff   = ctrl_q[C_G3] & real_m;
    assign q_neg    = ctrl_q[C_NEG] ^ ctrl_q[C_INV];
    assign sh       = dec_shift(ctrl_q[C_DEC +: C_DECW]);
    assign last_cnt = CNT_W'((6'h01 << sh) - 6'h01);
    assign align_ev = ctrl_q[C_ALN] & (al2_q ^ al3_q);
    assign restart  = (ctrl_q[C_RST] ^ rst_prev_q) | align_ev;

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[S_OVR] = ovr_q;
        status_w[S_PEND] = pend_q;
        status_w[S_CNT +: FCNT_W] = fifo_cnt;
        status_w[S_ALN] = al2_q;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            ctrl_q      <= CTRL_RST;
            freq_pend_q <= FREQ_RST;
            freq_act_q  <= FREQ_RST;
            pend_q      <= 1'b0;
            ovr_q       <= 1'b0;
            rst_prev_q  <= 1'b0;
            al1_q       <= 1'b0;
            al2_q       <= 1'b0;
            al3_q       <= 1'b0;
        end else begin
            al1_q      <= POWERDOWN_OR_ALIGN_PIN_IN;
            al2_q      <= al1_q;
            al3_q      <= al2_q;
            rst_prev_q <= ctrl_q[C_RST];
            if (wr_ctrl) begin
                ctrl_q <= HWDATA_IN[CTRL_W-1:0];
            end
            if (wr_freq) begin
                freq_pend_q <= HWDATA_IN;
            end
            if (restart) begin
                freq_act_q <= freq_pend_q;
            end
            pend_q <= wr_freq | (pend_q & ~restart);
            ovr_q  <= ovr_set | (ovr_q & ~(wr_stat & HWDATA_IN[S_OVR]));
        end
    end

    // oscillator and mixer
    assign idx    = phase_q[PHASE_W-1 -: LUT_W];
    assign cos_v  = lut_cos(idx);
    assign sin_v  = lut_cos(idx - LUT_QTR);
    assign prod_i = ADC_DATA_IN * cos_v;
    assign prod_q = ADC_DATA_IN * sin_v;
    assign q_raw  = prod_q[PROD_MSB:PROD_LSB];
    assign mix_i  = real_m ? {ADC_DATA_IN, {(DW-ADC_W){1'b0}}}
                           : prod_i[PROD_MSB:PROD_LSB];
    assign mix_q  = real_m ? WORD_ZERO : (q_neg ? -q_raw : q_raw);

    // boxcar decimator
    assign sum_i   = acc_i_q + acc_t'(mix_i);
    assign sum_q   = acc_q_q + acc_t'(mix_q);
    assign is_last = cnt_q == last_cnt;
    assign accept  = ADC_VALID_IN & en & ~restart & (~is_last | stage_free);
    assign load    = accept & is_last;
    assign ovr_set = ADC_VALID_IN & en & ~restart & is_last & ~stage_free;

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            phase_q <= '0;
            acc_i_q <= '0;
            acc_q_q <= '0;
            cnt_q   <= '0;
        end else if (restart) begin
            phase_q <= '0;
            acc_i_q <= '0;
            acc_q_q <= '0;
            cnt_q   <= '0;
        end else if (accept) begin
            if (!real_m) begin
                phase_q <= phase_q + freq_act_q;
            end
            acc_i_q <= is_last ? '0 : sum_i;
            acc_q_q <= is_last ? '0 : sum_q;
            cnt_q   <= is_last ? '0 : cnt_q + 1'b1;
        end
    end

    // output stage
    assign push       = (st_q != ST_EMPTY) & fifo_in_ready;
    assign stage_free = (st_q == ST_EMPTY) |
                        (push & ~((st_q == ST_ONE) & st_fs4_q));

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_EMPTY: begin
                if (load) st_d = ST_ONE;
            end
            ST_ONE: begin
                if (push) st_d = st_fs4_q ? ST_TWO
                                          : (load ? ST_ONE : ST_EMPTY);
            end
            ST_TWO: begin
                if (push) st_d = load ? ST_ONE : ST_EMPTY;
            end
            default: st_d = ST_EMPTY;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            st_q      <= ST_EMPTY;
            st_i_q    <= WORD_ZERO;
            st_qd_q   <= WORD_ZERO;
            st_fs4_q  <= 1'b0;
            st_real_q <= 1'b0;
            st_rot_q  <= 1'b0;
            rot_q     <= 1'b0;
        end else begin
            st_q <= st_d;
            if (restart) begin
                rot_q <= 1'b0;
            end else if (load) begin
                rot_q <= rot_q ^ fs4_eff;
            end
            if (load) begin
                st_i_q    <= gain_sat(sum_i >>> sh, g6_eff, g3_eff);
                st_qd_q   <= gain_sat(sum_q >>> sh, g6_eff, g3_eff);
                st_fs4_q  <= fs4_eff;
                st_real_q <= real_m;
                st_rot_q  <= rot_q;
            end
        end
    end

    // quarter-rate mix: I, -Q, -I, Q, ...
    assign fs4_w = (st_q == ST_TWO)
                 ? (st_rot_q ? st_qd_q : neg_sat(st_qd_q))
                 : (st_rot_q ? neg_sat(st_i_q) : st_i_q);
    assign fifo_in = st_fs4_q  ? {1'b1, fs4_w, WORD_ZERO} :
                     st_real_q ? {1'b1, st_i_q, WORD_ZERO} :
                                 {1'b0, st_i_q, st_qd_q};

    sync_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CLK_IN),
        .rstn_in       (RSTN_IN),
        .in_valid_in   (st_q != ST_EMPTY),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out),
        .count_out     (fifo_cnt)
    );

    assign fifo_out_ready = ~out_v_q | OUT_READY_IN;

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            out_v_q <= 1'b0;
            out_q   <= '0;
        end else begin
            out_v_q <= fifo_out_valid | (out_v_q & ~OUT_READY_IN);
            if (fifo_out_valid & fifo_out_ready) begin
                out_q <= fifo_out;
            end
        end
    end

    assign OUT_SAMPLE_OUT = out_q;
    assign OUT_VALID_OUT  = out_v_q;
endmodule // decimating_down_converter

/* File: decimating_down_converter_tb_top.sv */
`timescale 1ns/1ps
module decimating_down_converter_tb_top;
    import ddc_pkg::*;
    logic                    clk = 1'b0, rstn = 1'b0, pin = 1'b0;
    logic                    hsel = 1'b0, hwrite = 1'b0, adc_v = 1'b0;
    logic [1:0]              htrans = 2'h0, mode = 2'h0;
    logic [31:0]             haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic                    hrdy, ovalid, ordy;
    logic signed [ADC_W-1:0] adc = 18'h00000, x;
    logic signed [31:0]      q0, r;
    logic [11:0]             cur = 12'h000;
    sample_t                 osmp;
    int                      errors = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    decimating_down_converter u_decimating_down_converter (
        .CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .ADC_DATA_IN(adc),
        .ADC_VALID_IN(adc_v), .POWERDOWN_OR_ALIGN_PIN_IN(pin),
        .OUT_SAMPLE_OUT(osmp), .OUT_VALID_OUT(ovalid),
        .OUT_READY_IN(ordy));
    formatter_model u_formatter_model (
        .clk_in(clk), .rstn_in(rstn), .mode_in(mode), .sample_in(osmp),
        .valid_in(ovalid), .ready_out(ordy));
    function automatic word_t gi(input int j);
        return u_formatter_model.got[j].i;
    endfunction
    function automatic word_t gq(input int j);
        return u_formatter_model.got[j].q;
    endfunction
    function automatic word_t exp_real(input logic signed [ADC_W-1:0] v);
        return word_t'(v) <<< 2;
    endfunction
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task near(input string nm, input logic signed [31:0] e, g, tol);
        total_checks++;
        if (((g - e) <= tol && (e - g) <= tol) !== 1'b1) begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        rd = hrdata;
    endtask
    task set_ctrl(input logic [11:0] v);
        cur = (v | (cur & 12'h080)) ^ 12'h080;
        ahb(1'b1, {24'h0, A_CTRL}, {20'h0, cur});
        repeat (2) @(posedge clk);
        u_formatter_model.got.delete();
    endtask
    task feed(input logic signed [ADC_W-1:0] v, input int n);
        int c;
        c = 0;
        while (c < n) begin
            adc <= v;
            adc_v <= ($urandom_range(3) != 0);
            @(posedge clk);
            if (adc_v) c++;
        end
        adc_v <= 1'b0;
        @(posedge clk);
    endtask
    task collect(input int k);
        for (int t = 0; t < 600 && u_formatter_model.got.size() < k; t++)
            @(posedge clk);
        repeat (8) @(posedge clk);
        cmp("count", 64'(k), 64'(u_formatter_model.got.size()));
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        print_verdict;
    end
    initial begin
        void'($urandom(13168));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a += 4) begin
            ahb(1'b0, 32'(a), 32'h0);
            cmp("reset_value", 64'h0, 64'(rd));
        end
        ahb(1'b1, 32'h00000100, 32'hffffffff);
        ahb(1'b0, 32'h00000100, 32'h0);
        cmp("unmapped", 64'h0, 64'(rd));
        $display("registers done");
        mode <= 2'h1;
        for (int s = 0; s < 6; s++) begin
            x = 18'($urandom);
            set_ctrl(12'h003 | 12'(s << 9));
            feed(x, 4 << (s > 4 ? 4 : s));
            collect(2);
            for (int j = 0; j < 2; j++)
                cmp("real", 64'({1'b1, exp_real(x), WORD_ZERO}),
                    64'(u_formatter_model.got[j]));
        end
        x = 18'($urandom_range(60000, 20000));
        set_ctrl(12'h013);
        feed(x, 2);
        collect(1);
        r = exp_real(x);
        near("gain3", r * 1406 / 1000, 32'(gi(0)), r / 200 + 4);
        $display("real done");
        x = 18'($urandom_range(30000, 1000));
        set_ctrl(12'h001);
        feed(x, 2);
        collect(1);
        q0 = gi(0);
        cmp("cplx", 64'h3, {61'h0, u_formatter_model.got[0].is_real,
            gq(0) == WORD_ZERO, gi(0) > WORD_ZERO});
        set_ctrl(12'h009);
        feed(x, 2);
        collect(1);
        near("gain6", 2 * q0, 32'(gi(0)), 2);
        set_ctrl(12'h005);
        feed(x, 4);
        collect(4);
        for (int j = 0; j < 4; j++)
            cmp("fs4_real", 64'h1, 64'(u_formatter_model.got[j].is_real));
        cmp("fs4_zero", 64'h0, 64'({gi(1), gi(3)}));
        cmp("fs4_mirror", 64'(-gi(0)), 64'(gi(2)));
        $display("complex done");
        x = 18'sh10000;
        ahb(1'b1, {24'h0, A_FREQ}, 32'h10000000);
        for (int k = 0; k < 5; k++) begin
            if (k == 4) ahb(1'b1, {24'h0, A_FREQ}, 32'hf0000000);
            set_ctrl(12'h001 | 12'((k & 3) << 5));
            feed(x, 2);
            collect(1);
            if (k == 0) q0 = gq(0);
            cmp("rot_nz", 64'h1, 64'(q0 != 0));
            cmp("rotation", (k == 1 || k == 2 || k == 4) ? 64'(-q0) : 64'(q0),
                64'(gq(0)));
        end
        r = $urandom;
        ahb(1'b1, {24'h0, A_FREQ}, r);
        ahb(1'b0, {24'h0, A_ACT}, 32'h0);
        cmp("act_old", 64'hf0000000, 64'(rd));
        ahb(1'b0, {24'h0, A_STAT}, 32'h0);
        cmp("pending", 64'h1, 64'(rd[S_PEND]));
        set_ctrl(12'h001);
        ahb(1'b0, {24'h0, A_ACT}, 32'h0);
        cmp("act_new", {32'h0, r}, 64'(rd));
        set_ctrl(12'h101);
        r = $urandom;
        ahb(1'b1, {24'h0, A_FREQ}, r);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        ahb(1'b0, {24'h0, A_ACT}, 32'h0);
        cmp("act_pin", {32'h0, r}, 64'(rd));
        $display("oscillator done");
        mode <= 2'h2;
        set_ctrl(12'h003);
        for (int k = 0; k < 24; k++) feed(18'(1000 + 8 * k), 2);
        ahb(1'b0, {24'h0, A_STAT}, 32'h0);
        cmp("full", 64'(FIFO_DEPTH), 64'(rd[8:4]));
        cmp("overrun", 64'h1, 64'(rd[S_OVR]));
        mode <= 2'h1;
        repeat (300) @(posedge clk);
        cmp("drained", 64'h1,
            64'(u_formatter_model.got.size() >= FIFO_DEPTH));
        for (int j = 1; j < u_formatter_model.got.size(); j++)
            cmp("order", 64'h1, 64'(gi(j) > gi(j - 1)));
        ahb(1'b1, {24'h0, A_STAT}, 32'h1);
        ahb(1'b0, {24'h0, A_STAT}, 32'h0);
        cmp("cleared", 64'h0, 64'({rd[8:4], rd[S_OVR]}));
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, {24'h0, A_CTRL}, 32'h0);
        cmp("rereset", 64'h0, 64'(rd));
        $display("buffer done");
        print_verdict;
    end
endmodule // decimating_down_converter_tb_top

/* File: formatter_model.sv */
`timescale 1ns/1ps
module formatter_model
    import ddc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic [1:0] mode_in,
    input  wire sample_t    sample_in,
    input  wire logic       valid_in,
    output logic            ready_out
);
    sample_t got[$];
    initial ready_out = 1'b0;
    // mode 0 ready, 1 random stalls, 2 stalled
    always @(posedge clk_in) begin
        if (rstn_in && valid_in && ready_out) begin
            got.push_back(sample_in);
        end
        ready_out <= (mode_in == 2'h0) ||
                     (mode_in == 2'h1 && $urandom_range(1) == 1);
    end
endmodule // formatter_model

/* File: sync_fifo.sv */
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  in_valid_in,
    output logic                       in_ready_out,
    input  wire logic [WIDTH-1:0]      in_data_in,
    output logic                       out_valid_out,
    input  wire logic                  out_ready_in,
    output logic [WIDTH-1:0]           out_data_out,
    output logic [$clog2(DEPTH):0]     count_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             wr_en;
    logic             rd_en;

    assign in_ready_out  = cnt_q != FULL_CNT;
    assign out_valid_out = cnt_q != '0;
    assign wr_en         = in_valid_in & in_ready_out;
    assign rd_en         = out_valid_out & out_ready_in;
    assign out_data_out  = mem_q[rp_q];
    assign count_out     = cnt_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (wr_en) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd_en) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_en) begin
            mem_q[wp_q] <= in_data_in;
        end
    end
endmodule // sync_fifo
